// >>> src/acg_clock_gen.v
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

`include "acg_defines.vh"

// What this block does
// - Converter master clock runs at 256 reference rates
// - Master clock through divider or PLL
// - Bit clock or pin two may source it
// - Codec off: PLL passes pin two to one
// - Divider mode: reference equals source over 128Q
// - Divider source select at bits 7:6, register 102
// - PLL mode: reference equals in*K*R/(2048P)
// - PLL source select at bits 5:4, register 102
// - K is integer J plus D ten-thousandths
// - Select 0: pin one is in*2KR/(MNP)
// - Select 1: pin one is source*2/(MN)
// - PLL usable for pin one independently
// - ADC/DAC rates are reference, or twice, over ratio
module acg_clock_gen #(
	parameter ADDR_W = 12
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Clock pins, taken as synchronous to pclk
	input wire master_clk_in,
	input wire bit_clk_in,
	input wire general_pin_two_in,
	// General-purpose pin one
	output reg general_pin_one_out,
	output reg general_pin_one_oe_n,
	// Converter clocks
	output reg conv_master_clk,
	output reg adc_sample_stb,
	output reg dac_sample_stb
);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [5:0] ctrl_q;
reg [7:0] clk_src_q;
reg [4:0] div_q_q;
reg [3:0] pll_p_q;
reg [4:0] pll_r_q;
reg [5:0] pll_j_q;
reg [13:0] pll_d_q;
reg [1:0] out_m_q;
reg [4:0] out_n_q;
reg [3:0] dac_ratio_q;
reg [3:0] adc_ratio_q;
reg mclk_prev_q;
reg bclk_prev_q;
reg pin2_prev_q;

wire [9:0] idx;
wire setup;
wire wr_done;
wire mapped;
wire pll_en;
wire out_sel;
wire codec_pwr;
wire pin1_en;
wire [1:0] div_sel;
wire [1:0] pll_sel;

assign idx = paddr[11:2];
assign setup = psel && !penable;
assign wr_done = psel && penable && pready && pwrite;
assign mapped = (paddr[1:0] == 2'h0) && (idx == `ACG_IDX_CTRL ||
	idx == `ACG_IDX_DIVQ || idx == `ACG_IDX_PLL_PR ||
	idx == `ACG_IDX_PLL_K || idx == `ACG_IDX_OUT_MN ||
	idx == `ACG_IDX_RATIO || idx == `ACG_IDX_STATUS ||
	idx == `ACG_IDX_CLK_SRC);
assign pll_en = ctrl_q[`ACG_CTRL_PLL_EN];
assign out_sel = ctrl_q[`ACG_CTRL_OUT_SEL];
assign codec_pwr = ctrl_q[`ACG_CTRL_PWR];
assign pin1_en = ctrl_q[`ACG_CTRL_PIN1_EN];
assign div_sel = clk_src_q[`ACG_SRC_DIV_LSB+1:`ACG_SRC_DIV_LSB];
assign pll_sel = clk_src_q[`ACG_SRC_PLL_LSB+1:`ACG_SRC_PLL_LSB];

// ----------------------------------------------------------------
// Source edges
// ----------------------------------------------------------------
wire mclk_edge;
wire bclk_edge;
wire pin2_edge;
reg div_edge;
reg pll_edge;

assign mclk_edge = master_clk_in && !mclk_prev_q;
assign bclk_edge = bit_clk_in && !bclk_prev_q;
assign pin2_edge = general_pin_two_in && !pin2_prev_q;

always @* begin
	// Divider source: master, bit clock or pin two
	case (div_sel)
	`ACG_SRC_MCLK: div_edge = mclk_edge;
	`ACG_SRC_BCLK: div_edge = bclk_edge;
	`ACG_SRC_PIN2: div_edge = pin2_edge;
	default: div_edge = 1'b0;
	endcase
	// PLL source: master or bit clock, pin two for pass-through
	case (pll_sel)
	`ACG_SRC_MCLK: pll_edge = mclk_edge;
	`ACG_SRC_BCLK: pll_edge = bclk_edge;
	`ACG_SRC_PIN2: pll_edge = pin2_edge;
	default: pll_edge = 1'b0;
	endcase
end

// ----------------------------------------------------------------
// Ratio arithmetic, settings clamped to their legal ranges
// ----------------------------------------------------------------
wire [4:0] q_val;
wire [3:0] p_val;
wire [4:0] r_val;
wire [5:0] j_val;
wire [13:0] d_val;
wire [4:0] n_val;
wire [3:0] m_val;
wire [19:0] k4;
wire [23:0] k4_r;
wire [18:0] p4;
wire [7:0] mn;
wire [23:0] mnp4;

assign q_val = (div_q_q < 5'd2) ? 5'd2 : div_q_q;
assign p_val = (pll_p_q == 4'h0) ? 4'h1 :
	((pll_p_q > 4'h8) ? 4'h8 : pll_p_q);
assign r_val = (pll_r_q == 5'h00) ? 5'h01 :
	((pll_r_q > 5'h10) ? 5'h10 : pll_r_q);
assign j_val = (pll_j_q == 6'h00) ? 6'h01 : pll_j_q;
assign d_val = (pll_d_q > 14'd9999) ? 14'd9999 : pll_d_q;
assign n_val = (out_n_q < 5'd2) ? 5'd2 :
	((out_n_q > 5'd17) ? 5'd17 : out_n_q);
assign m_val = 4'h1 << out_m_q;
// K in ten-thousandths: J.D
assign k4 = {14'h0000, j_val} * `ACG_K_SCALE + {6'h00, d_val};
assign k4_r = {4'h0, k4} * {19'h00000, r_val};
// Converter clock toggles per PLL input edge: K*R/(4P)
assign p4 = {15'h0000, p_val} * `ACG_P4_SCALE;
assign mn = {4'h0, m_val} * {3'h0, n_val};
assign mnp4 = {16'h0000, mn} * {20'h00000, p_val} * `ACG_MNP_SCALE;

reg [25:0] mc_inc;
reg [23:0] mc_thr;
reg mc_edge;
reg [25:0] oc_inc;
reg [23:0] oc_thr;
reg oc_edge;

always @* begin
	if (pll_en) begin
		// PLL: master clock = in*K*R*256/(2048P)
		mc_edge = pll_edge;
		mc_inc = {2'h0, k4_r};
		mc_thr = {5'h00, p4};
	end else begin
		// Divider: master clock = src*256/(128Q)
		mc_edge = div_edge;
		mc_inc = 26'h0000004;
		mc_thr = {19'h00000, q_val};
	end
	if (out_sel) begin
		// Pin one = src*2/(M*N), any PLL state
		oc_edge = div_edge;
		oc_inc = 26'h0000004;
		oc_thr = {16'h0000, mn};
	end else begin
		// Pin one = in*2*K*R/(M*N*P)
		oc_edge = pll_edge;
		oc_inc = {k4_r, 2'h0};
		oc_thr = mnp4;
	end
end

// ----------------------------------------------------------------
// Generators
// ----------------------------------------------------------------
wire mc_clk;
wire mc_active;
wire oc_clk;
wire oc_active;
wire oc_run;

// PLL serves pin one even when converters are off, but only while the PLL is enabled
assign oc_run = pin1_en && (out_sel || pll_en);

acg_rate_gen #(
	.INC_W(26),
	.THR_W(24),
	.ACC_W(28)
) u_master_gen (
	.pclk(pclk),
	.presetn(presetn),
	.src_edge(mc_edge),
	.run(codec_pwr),
	.inc(mc_inc),
	.thr(mc_thr),
	.clk_out(mc_clk),
	.active(mc_active)
);

acg_rate_gen #(
	.INC_W(26),
	.THR_W(24),
	.ACC_W(28)
) u_out_gen (
	.pclk(pclk),
	.presetn(presetn),
	.src_edge(oc_edge),
	.run(oc_run),
	.inc(oc_inc),
	.thr(oc_thr),
	.clk_out(oc_clk),
	.active(oc_active)
);

// ----------------------------------------------------------------
// Sample strobes
// ----------------------------------------------------------------
reg mc_prev_q;
wire mc_rise;
wire [1:0] stb;

assign mc_rise = mc_clk && !mc_prev_q;

genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : g_rate
		wire [3:0] ratio;
		wire dual;
		wire [10:0] period;
		reg [10:0] cnt_q;
		assign ratio = (g == 0) ? adc_ratio_q : dac_ratio_q;
		assign dual = (g == 0) ? ctrl_q[`ACG_CTRL_ADC_DUAL] :
			ctrl_q[`ACG_CTRL_DAC_DUAL];
		// 256*(n+2)/2 master cycles, halved in dual rate
		assign period = dual ? {3'h0, ratio + 4'h2, 4'h0} * 11'd4 :
			{3'h0, ratio + 4'h2, 4'h0} * 11'd8;
		assign stb[g] = mc_rise && (cnt_q >= period - 11'd1);
		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_q <= 11'h000;
			end else if (!codec_pwr) begin
				cnt_q <= 11'h000;
			end else if (stb[g]) begin
				cnt_q <= 11'h000;
			end else if (mc_rise) begin
				cnt_q <= cnt_q + 11'h001;
			end
		end
	end
endgenerate

// ----------------------------------------------------------------
// Status
// ----------------------------------------------------------------
wire cfg_err;

// Flags an odd divisor paired with a half-step DAC ratio
assign cfg_err = !pll_en && q_val[0] && dac_ratio_q[0];

// ----------------------------------------------------------------
// Register file and outputs
// ----------------------------------------------------------------
reg [31:0] rd_d;

always @* begin
	rd_d = 32'h00000000;
	case (idx)
	`ACG_IDX_CTRL: rd_d[5:0] = ctrl_q;
	`ACG_IDX_CLK_SRC: rd_d[7:0] = clk_src_q;
	`ACG_IDX_DIVQ: rd_d[4:0] = div_q_q;
	`ACG_IDX_PLL_PR: rd_d = {19'h00000, pll_r_q, 4'h0, pll_p_q};
	`ACG_IDX_PLL_K: rd_d = {10'h000, pll_j_q, 2'h0, pll_d_q};
	`ACG_IDX_OUT_MN: rd_d = {19'h00000, out_n_q, 6'h00, out_m_q};
	`ACG_IDX_RATIO: rd_d = {20'h00000, adc_ratio_q, 4'h0, dac_ratio_q};
	`ACG_IDX_STATUS: rd_d = {27'h0000000, oc_active, mc_active,
		cfg_err, oc_clk, mc_clk};
	default: rd_d = 32'h00000000;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
		ctrl_q <= `ACG_RST_CTRL;
		clk_src_q <= `ACG_RST_CLK_SRC;
		div_q_q <= `ACG_RST_Q;
		pll_p_q <= `ACG_RST_P;
		pll_r_q <= `ACG_RST_R;
		pll_j_q <= `ACG_RST_J;
		pll_d_q <= `ACG_RST_D;
		out_m_q <= `ACG_RST_M;
		out_n_q <= `ACG_RST_N;
		dac_ratio_q <= `ACG_RST_RATIO;
		adc_ratio_q <= `ACG_RST_RATIO;
		mclk_prev_q <= 1'b0;
		bclk_prev_q <= 1'b0;
		pin2_prev_q <= 1'b0;
		mc_prev_q <= 1'b0;
		conv_master_clk <= 1'b0;
		general_pin_one_out <= 1'b0;
		general_pin_one_oe_n <= 1'b1;
		adc_sample_stb <= 1'b0;
		dac_sample_stb <= 1'b0;
	end else begin
		// No wait state: answer prepared in setup, given in first access cycle
		pready <= setup;
		if (setup) begin
			pslverr <= !mapped;
			prdata <= (mapped && !pwrite) ? rd_d : 32'h00000000;
		end else begin
			pslverr <= 1'b0;
		end
		if (wr_done && mapped) begin
			case (idx)
			`ACG_IDX_CTRL: ctrl_q <= pwdata[5:0];
			`ACG_IDX_CLK_SRC: clk_src_q <= pwdata[7:0];
			`ACG_IDX_DIVQ: div_q_q <= pwdata[4:0];
			`ACG_IDX_PLL_PR: begin
				pll_p_q <= pwdata[`ACG_P_LSB+3:`ACG_P_LSB];
				pll_r_q <= pwdata[`ACG_R_LSB+4:`ACG_R_LSB];
			end
			`ACG_IDX_PLL_K: begin
				pll_d_q <= pwdata[`ACG_D_LSB+13:`ACG_D_LSB];
				pll_j_q <= pwdata[`ACG_J_LSB+5:`ACG_J_LSB];
			end
			`ACG_IDX_OUT_MN: begin
				out_m_q <= pwdata[`ACG_M_LSB+1:`ACG_M_LSB];
				out_n_q <= pwdata[`ACG_N_LSB+4:`ACG_N_LSB];
			end
			`ACG_IDX_RATIO: begin
				dac_ratio_q <= (pwdata[3:0] > 4'hA) ? 4'hA : pwdata[3:0];
				adc_ratio_q <= (pwdata[11:8] > 4'hA) ? 4'hA :
					pwdata[11:8];
			end
			default: ctrl_q <= ctrl_q;
			endcase
		end
		mclk_prev_q <= master_clk_in;
		bclk_prev_q <= bit_clk_in;
		pin2_prev_q <= general_pin_two_in;
		mc_prev_q <= mc_clk;
		conv_master_clk <= mc_clk;
		general_pin_one_out <= oc_clk;
		general_pin_one_oe_n <= !pin1_en;
		adc_sample_stb <= stb[0];
		dac_sample_stb <= stb[1];
	end
end

endmodule // acg_clock_gen

`default_nettype wire

// >>> inc/acg_defines.vh
`ifndef ACG_DEFINES_VH
`define ACG_DEFINES_VH

// ----------------------------------------------------------------
// Clock and documented ranges
// ----------------------------------------------------------------
`define ACG_PCLK_HZ 25000000
`define ACG_MCLK_MIN_HZ 512000
`define ACG_MCLK_MAX_HZ 50000000
`define ACG_MCLK_PER_FS 256
`define ACG_DIV_FS_FACTOR 128
`define ACG_PLL_FS_FACTOR 2048
`define ACG_FRAC_SCALE 10000
`define ACG_K_SCALE 20'h02710
`define ACG_P4_SCALE 19'h09C40
`define ACG_MNP_SCALE 24'h002710

// ----------------------------------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------------------------------
`define ACG_IDX_CTRL 10'h000
`define ACG_IDX_DIVQ 10'h001
`define ACG_IDX_PLL_PR 10'h002
`define ACG_IDX_PLL_K 10'h003
`define ACG_IDX_OUT_MN 10'h004
`define ACG_IDX_RATIO 10'h005
`define ACG_IDX_STATUS 10'h006
`define ACG_IDX_CLK_SRC 10'h066

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACG_CTRL_PLL_EN 0
`define ACG_CTRL_OUT_SEL 1
`define ACG_CTRL_PWR 2
`define ACG_CTRL_PIN1_EN 3
`define ACG_CTRL_ADC_DUAL 4
`define ACG_CTRL_DAC_DUAL 5
`define ACG_SRC_DIV_LSB 6
`define ACG_SRC_PLL_LSB 4
`define ACG_Q_LSB 0
`define ACG_P_LSB 0
`define ACG_R_LSB 8
`define ACG_D_LSB 0
`define ACG_J_LSB 16
`define ACG_M_LSB 0
`define ACG_N_LSB 8
`define ACG_DAC_RATIO_LSB 0
`define ACG_ADC_RATIO_LSB 8

// ----------------------------------------------------------------
// Source codes and reset values
// ----------------------------------------------------------------
`define ACG_SRC_MCLK 2'h0
`define ACG_SRC_BCLK 2'h1
`define ACG_SRC_PIN2 2'h2
`define ACG_RST_CTRL 6'h00
`define ACG_RST_CLK_SRC 8'h00
`define ACG_RST_Q 5'h02
`define ACG_RST_P 4'h1
`define ACG_RST_R 5'h01
`define ACG_RST_J 6'h01
`define ACG_RST_D 14'h0000
`define ACG_RST_M 2'h0
`define ACG_RST_N 5'h02
`define ACG_RST_RATIO 4'h0

`endif

// >>> src/acg_rate_gen.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Fractional rate generator: output toggles per source edge = inc/thr
// ----------------------------------------------------------------
module acg_rate_gen #(
	parameter INC_W = 26,
	parameter THR_W = 24,
	parameter ACC_W = 28
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control
	input wire src_edge,
	input wire run,
	input wire [INC_W-1:0] inc,
	input wire [THR_W-1:0] thr,
	// Clock out
	output wire clk_out,
	output wire active
);

reg clk_q;
reg [ACC_W-1:0] acc_q;
reg [INC_W-1:0] inc_q;
reg [THR_W-1:0] thr_q;
wire act;
wire fire;
wire add_ok;
wire [ACC_W-1:0] thr_w;
wire [ACC_W-1:0] inc_w;

assign act = run | clk_q;
assign thr_w = {{(ACC_W-THR_W){1'b0}}, thr_q};
assign inc_w = {{(ACC_W-INC_W){1'b0}}, inc_q};
assign fire = act && (thr_q != {THR_W{1'b0}}) && (acc_q >= thr_w);
assign add_ok = src_edge && !acc_q[ACC_W-1];
assign clk_out = clk_q;
assign active = act;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		clk_q <= 1'b0;
		acc_q <= {ACC_W{1'b0}};
		inc_q <= {INC_W{1'b0}};
		thr_q <= {THR_W{1'b0}};
	end else begin
		// Settings change only while the output rests low
		if (!clk_q) begin
			inc_q <= inc;
			thr_q <= thr;
		end
		if (!act) begin
			acc_q <= {ACC_W{1'b0}};
		end else begin
			acc_q <= acc_q + (add_ok ? inc_w : {ACC_W{1'b0}})
				- (fire ? thr_w : {ACC_W{1'b0}});
		end
		if (fire) begin
			clk_q <= ~clk_q;
		end
	end
end

endmodule // acg_rate_gen

`default_nettype wire

// >>> dv/acg_clk_src.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// External clock source on the three clock pins
// ----
module acg_clk_src (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Clock pins
	output wire logic mclk,
	output wire logic bclk,
	output wire logic pin2
);
	int cnt_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_q <= 0;
		else
			cnt_q <= cnt_q + 1;
	end
	// Periods of 4, 6 and 10 cycles keep every pin below pclk/2
	assign mclk = (cnt_q % 4) >= 2;
	assign bclk = (cnt_q % 6) >= 3;
	assign pin2 = (cnt_q % 10) >= 5;
endmodule // acg_clk_src
`default_nettype wire

// >>> dv/acg_clock_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module acg_clock_chk #(
	parameter ADDR_W = 12
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Outputs
	input wire logic general_pin_one_oe_n,
	input wire logic conv_master_clk,
	input wire logic adc_sample_stb
);
	logic wr;
	logic [5:0] ctrl_q;
	logic [3:0] src_q;
	logic [1:0] oe_bad_q;
	logic [10:0] off_q;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	// Shadow of control fields and lag counters
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 6'h00;
			src_q <= 4'h0;
			oe_bad_q <= 2'h0;
			off_q <= 11'h000;
		end else begin
			if (wr && paddr == 12'h000)
				ctrl_q <= pwdata[5:0];
			if (wr && paddr == 12'h198)
				src_q <= pwdata[7:4];
			if (general_pin_one_oe_n != ctrl_q[3])
				oe_bad_q <= 2'h0;
			else if (oe_bad_q != 2'h3)
				oe_bad_q <= oe_bad_q + 2'h1;
			if (ctrl_q[2])
				off_q <= 11'h000;
			else if (off_q != 11'h7FF)
				off_q <= off_q + 11'h001;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_ready_next; psel && !penable |=> pready; endproperty
	a_ready_next: assert property (p_ready_next)
		else $error("ready missing after setup");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready longer than one cycle");
	property p_err_ready; pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready)
		else $error("error without ready");
	property p_misalign; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr;
	endproperty
	a_misalign: assert property (p_misalign)
		else $error("misaligned access not refused");
	property p_src_read;
		pready && !pwrite && paddr == 12'h198 |-> prdata[7:4] == src_q;
	endproperty
	a_src_read: assert property (p_src_read)
		else $error("source select readback wrong");
	property p_pin_oe; oe_bad_q != 2'h3; endproperty
	a_pin_oe: assert property (p_pin_oe)
		else $error("pin one drive does not follow enable");
	property p_conv_idle; off_q == 11'h7FF |-> !conv_master_clk; endproperty
	a_conv_idle: assert property (p_conv_idle)
		else $error("converter clock runs while unpowered");
	property p_adc_pulse; adc_sample_stb |=> !adc_sample_stb; endproperty
	a_adc_pulse: assert property (p_adc_pulse)
		else $error("sample strobe longer than one cycle");
endmodule // acg_clock_chk

bind acg_clock_gen acg_clock_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .general_pin_one_oe_n(general_pin_one_oe_n),
	.conv_master_clk(conv_master_clk), .adc_sample_stb(adc_sample_stb));
`default_nettype wire

// >>> dv/audio_clock_generation_tb.sv
`timescale 1ns/1ps
`default_nettype none
module audio_clock_generation_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, pin_out, pin_oe_n, conv, adc_stb, dac_stb;
	logic mclk, bclk, pin2;
	int seed = 35874;
	int bad_count = 0;
	int checks = 0;
	int nc, np, na, nd, q, s, e, kk, p, m, n, mn, x;
	int per [3] = '{240, 160, 96};
	logic [11:0] rst_a [7] = '{12'h000, 12'h004, 12'h008, 12'h00C,
		12'h010, 12'h014, 12'h198};
	logic [31:0] rst_v [7] = '{32'h0, 32'h2, 32'h101, 32'h10000, 32'h200,
		32'h0, 32'h0};
	always #20 pclk = ~pclk;
	acg_clk_src u_src (.pclk(pclk), .presetn(presetn), .mclk(mclk),
		.bclk(bclk), .pin2(pin2));
	acg_clock_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.master_clk_in(mclk), .bit_clk_in(bclk), .general_pin_two_in(pin2),
		.general_pin_one_out(pin_out), .general_pin_one_oe_n(pin_oe_n),
		.conv_master_clk(conv), .adc_sample_stb(adc_stb),
		.dac_sample_stb(dac_stb));
	// ----
	// Helpers
	// ----
	function automatic int rnd(input int lim);
		return $unsigned($random(seed)) % lim;
	endfunction
	function automatic logic near(input int sv, input int xv, input int t);
		return sv >= xv - t && sv <= xv + t;
	endfunction
	function automatic int rate(input int ed, input int num, input int den);
		return ed * num / den;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input int d);
		int wt;
		wt = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && wt < 50) begin
			wt++;
			@(posedge pclk);
		end
		if (pready !== 1'b1)
			bad_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic measure(input int cyc);
		logic lc, lp;
		repeat (200) @(posedge pclk);
		lc = conv;
		lp = pin_out;
		nc = 0;
		np = 0;
		na = 0;
		nd = 0;
		repeat (cyc) begin
			@(posedge pclk);
			nc += int'(conv && !lc);
			np += int'(pin_out && !lp);
			na += int'(adc_stb === 1'b1);
			nd += int'(dac_stb === 1'b1);
			lc = conv;
			lp = pin_out;
		end
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b1, 12'h005, 32'h1F);
		check(err, 1'b1, "misaligned error");
		apb(1'b0, 12'h0FC, 32'h0);
		check(err, 1'b1, "unmapped error");
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, rst_a[i], 32'h0);
			check(rd, rst_v[i], "reset value");
		end
		for (s = 0; s < 3; s++) begin
			q = s == 0 ? 1 : 2 + rnd(16);
			m = rnd(4);
			n = 2 + rnd(16);
			mn = (1 << m) * n;
			apb(1'b1, 12'h198, s << 6 | 32'h30);
			apb(1'b1, 12'h004, q);
			apb(1'b1, 12'h010, n << 8 | m);
			apb(1'b1, 12'h000, 32'h0E);
			apb(1'b0, 12'h198, 32'h0);
			check(rd[7:4], s << 2 | 3, "source select");
			measure(960);
			x = rate(per[s], 2, q < 2 ? 2 : q);
			check(near(nc, x, 2), 1'b1, "conv rate");
			check(near(np, rate(per[s], 2, mn), 2), 1'b1, "pin rate");
			check(pin_oe_n, 1'b0, "pin one drive");
		end
		// Integer ratios with divisor 2, both strobes at dual rate
		apb(1'b1, 12'h198, 32'h0);
		apb(1'b1, 12'h004, 32'h2);
		apb(1'b1, 12'h014, 32'h200);
		apb(1'b1, 12'h000, 32'h34);
		measure(4096);
		check(near(nd, rate(1024, 1, 128), 1), 1'b1, "dac strobes");
		check(near(na, rate(1024, 1, 256), 1), 1'b1, "adc strobes");
		for (s = 0; s < 3; s++) begin
			p = 1 + rnd(8);
			kk = (4 + rnd(5)) * 10000 + rnd(10000);
			m = rnd(4);
			n = 10 + rnd(8);
			mn = (1 << m) * n;
			apb(1'b1, 12'h198, s << 4);
			apb(1'b1, 12'h008, 32'h100 | p);
			apb(1'b1, 12'h00C, (kk / 10000) << 16 | kk % 10000);
			apb(1'b1, 12'h010, n << 8 | m);
			apb(1'b1, 12'h000, s == 2 ? 32'h09 : 32'h0D);
			measure(s == 2 ? 2400 : 960);
			e = s == 2 ? 240 : per[s];
			x = s == 2 ? 0 : rate(e, kk, 80000 * p);
			check(near(nc, x, 2), 1'b1, "pll conv rate");
			x = rate(e, 2 * kk, 10000 * mn * p);
			check(near(np, x, 2), 1'b1, "pll pin rate");
		end
		conclude();
	end
	initial begin
		#2000000;
		bad_count++;
		conclude();
	end
endmodule // audio_clock_generation_tb
`default_nettype wire
